// *** tsc_cfg.svh ***
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

// ----------------------------------------
// Bus and datapath widths
// ----------------------------------------
`define TSC_ADDR_W        12
`define TSC_DATA_W        32
`define TSC_CNT_W         16
`define TSC_FLAG_W        3

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TSC_OFS_STATUS    12'h000
`define TSC_OFS_ENABLE    12'h004
`define TSC_OFS_COUNT     12'h008
`define TSC_OFS_CMP_A     12'h00C
`define TSC_OFS_CMP_B     12'h010

// ----------------------------------------
// Flag and enable bit positions
// ----------------------------------------
`define TSC_BIT_MATCH_A   0
`define TSC_BIT_MATCH_B   1
`define TSC_BIT_OVF       2

// ----------------------------------------
// Reset values and counter limits
// ----------------------------------------
`define TSC_RST_FLAGS     3'h0
`define TSC_RST_ENABLE    3'h0
`define TSC_RST_CMP       16'h0000
`define TSC_RST_DATA      32'h0000_0000
`define TSC_CNT_MAX       16'hFFFF

`endif

// *** tsc_pkg.sv ***
`include "tsc_cfg.svh"

package tsc_pkg;

    typedef logic [`TSC_CNT_W-1:0]  tsc_cnt_t;
    typedef logic [`TSC_FLAG_W-1:0] tsc_flag_t;
    typedef logic [`TSC_DATA_W-1:0] tsc_word_t;

    typedef enum logic [2:0] {
        TSC_SEL_STATUS,
        TSC_SEL_ENABLE,
        TSC_SEL_COUNT,
        TSC_SEL_CMP_A,
        TSC_SEL_CMP_B,
        TSC_SEL_NONE
    } tsc_sel_t;

endpackage : tsc_pkg

// *** tsc_evt_if.sv ***
`timescale 1ns/1ns

interface tsc_evt_if;
    import tsc_pkg::*;

    tsc_cnt_t  count;
    tsc_cnt_t  cmp_a;
    tsc_cnt_t  cmp_b;
    tsc_flag_t events;
    tsc_flag_t clear;
    tsc_flag_t flags;

    modport detect (input count, input cmp_a, input cmp_b, output events);
    modport bank   (input events, input clear, output flags);
    modport ctl    (output count, output cmp_a, output cmp_b, output clear, input events, input flags);
endinterface : tsc_evt_if

// *** tsc_event_detect.sv ***
`timescale 1ns/1ns
`include "tsc_cfg.svh"

module tsc_event_detect
    import tsc_pkg::*;
(
    // Clock and reset
    input  wire logic  clk_in,
    input  wire logic  reset_in,
    // Event channel
    tsc_evt_if.detect  evt
);

    tsc_cnt_t prev_q;
    logic     prev_vld_q;
    logic     advanced;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            prev_q     <= `TSC_RST_CMP;
            prev_vld_q <= 1'b0;
        end else begin
            prev_q     <= evt.count;
            prev_vld_q <= 1'b1;
        end
    end

    // Match only on entry, so a counter parked on the value does not refire
    assign advanced = prev_vld_q && (prev_q != evt.count);

    always_comb begin
        evt.events = `TSC_RST_FLAGS;
        evt.events[`TSC_BIT_OVF]     = prev_vld_q && (prev_q == `TSC_CNT_MAX) && (evt.count == '0);
        evt.events[`TSC_BIT_MATCH_B] = advanced && (evt.count == evt.cmp_b);
        evt.events[`TSC_BIT_MATCH_A] = advanced && (evt.count == evt.cmp_a);
    end

endmodule : tsc_event_detect

// *** tsc_flag_bank.sv ***
`timescale 1ns/1ns
`include "tsc_cfg.svh"

module tsc_flag_bank
    import tsc_pkg::*;
(
    // Clock and reset
    input  wire logic  clk_in,
    input  wire logic  reset_in,
    // Event channel
    tsc_evt_if.bank    evt
);

    tsc_flag_t flags_q;

    // Set wins over a coinciding clear; mask plays no part here
    for (genvar i = 0; i < `TSC_FLAG_W; i++) begin : g_flag
        always_ff @(posedge clk_in or posedge reset_in) begin
            if (reset_in) begin
                flags_q[i] <= 1'b0;
            end else begin
                flags_q[i] <= (flags_q[i] & ~evt.clear[i]) | evt.events[i];
            end
        end
    end

    assign evt.flags = flags_q;

endmodule : tsc_flag_bank

// *** tsc_timer_status.sv ***
`timescale 1ns/1ns
`include "tsc_cfg.svh"

module tsc_timer_status
    import tsc_pkg::*;
#(
    parameter int ADDR_W = `TSC_ADDR_W
)
(
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    // APB slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire tsc_word_t         pwdata_in,
    output logic                   pready_out,
    output tsc_word_t              prdata_out,
    output logic                   pslverr_out,
    // Timer channel
    input  wire tsc_cnt_t          count_in,
    // Interrupt
    output logic                   irq_out
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    tsc_evt_if evt ();

    tsc_sel_t  sel;
    logic      setup;
    logic      done;
    logic      wr_done;
    logic      rd_done;

    logic      pready_q;
    tsc_word_t prdata_q;
    logic      pslverr_q;
    logic      irq_q;
    tsc_flag_t enable_q;
    tsc_cnt_t  cmp_a_q;
    tsc_cnt_t  cmp_b_q;
    tsc_flag_t reported_q;
    tsc_word_t rd_word;

    // ----------------------------------------
    // Event detection and sticky flags
    // ----------------------------------------
    tsc_event_detect u_detect (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .evt      (evt.detect)
    );

    tsc_flag_bank u_flags (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .evt      (evt.bank)
    );

    assign evt.count = count_in;
    assign evt.cmp_a = cmp_a_q;
    assign evt.cmp_b = cmp_b_q;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    always_comb begin
        case (paddr_in)
            ADDR_W'(`TSC_OFS_STATUS): sel = TSC_SEL_STATUS;
            ADDR_W'(`TSC_OFS_ENABLE): sel = TSC_SEL_ENABLE;
            ADDR_W'(`TSC_OFS_COUNT):  sel = TSC_SEL_COUNT;
            ADDR_W'(`TSC_OFS_CMP_A):  sel = TSC_SEL_CMP_A;
            ADDR_W'(`TSC_OFS_CMP_B):  sel = TSC_SEL_CMP_B;
            default:                  sel = TSC_SEL_NONE;
        endcase
    end

    // Registered pready: one access cycle per transfer
    assign setup   = psel_in && !penable_in && !pready_q;
    assign done    = psel_in && penable_in && pready_q;
    assign wr_done = done && pwrite_in;
    assign rd_done = done && !pwrite_in;

    // ----------------------------------------
    // Read data mux
    // ----------------------------------------
    always_comb begin
        case (sel)
            TSC_SEL_STATUS: rd_word = `TSC_DATA_W'(evt.flags);
            TSC_SEL_ENABLE: rd_word = `TSC_DATA_W'(enable_q);
            TSC_SEL_COUNT:  rd_word = `TSC_DATA_W'(count_in);
            TSC_SEL_CMP_A:  rd_word = `TSC_DATA_W'(cmp_a_q);
            TSC_SEL_CMP_B:  rd_word = `TSC_DATA_W'(cmp_b_q);
            default:        rd_word = `TSC_RST_DATA;
        endcase
    end

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && (sel == TSC_SEL_NONE);
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            prdata_q <= `TSC_RST_DATA;
        end else if (setup) begin
            prdata_q <= pwrite_in ? `TSC_RST_DATA : rd_word;
        end
    end

    // ----------------------------------------
    // Read-to-clear of status
    // ----------------------------------------
    // Clear only what the reader saw; later events survive the read
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            reported_q <= `TSC_RST_FLAGS;
        end else if (setup) begin
            reported_q <= (!pwrite_in && sel == TSC_SEL_STATUS) ? evt.flags : `TSC_RST_FLAGS;
        end
    end

    assign evt.clear = (rd_done && sel == TSC_SEL_STATUS) ? reported_q : `TSC_RST_FLAGS;

    // ----------------------------------------
    // Writable registers
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            enable_q <= `TSC_RST_ENABLE;
        end else if (wr_done && sel == TSC_SEL_ENABLE) begin
            enable_q <= pwdata_in[`TSC_FLAG_W-1:0];
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cmp_a_q <= `TSC_RST_CMP;
        end else if (wr_done && sel == TSC_SEL_CMP_A) begin
            cmp_a_q <= pwdata_in[`TSC_CNT_W-1:0];
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cmp_b_q <= `TSC_RST_CMP;
        end else if (wr_done && sel == TSC_SEL_CMP_B) begin
            cmp_b_q <= pwdata_in[`TSC_CNT_W-1:0];
        end
    end

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    // Registered to keep the output glitch free, at one cycle of latency
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt.flags & enable_q);
        end
    end

    assign pready_out  = pready_q;
    assign prdata_out  = prdata_q;
    assign pslverr_out = pslverr_q;
    assign irq_out     = irq_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking

    default disable iff (reset_in);

    property p_ovf_sets;
        evt.events[`TSC_BIT_OVF] |=> evt.flags[`TSC_BIT_OVF];
    endproperty
    a_ovf_sets: assert property (p_ovf_sets) else $error("overflow flag not set");

    property p_match_b_sets;
        evt.events[`TSC_BIT_MATCH_B] |=> evt.flags[`TSC_BIT_MATCH_B];
    endproperty
    a_match_b_sets: assert property (p_match_b_sets) else $error("match B flag not set");

    property p_match_a_sets;
        (count_in == cmp_a_q) && ($past(count_in) != count_in) && !$past(reset_in)
            |=> evt.flags[`TSC_BIT_MATCH_A];
    endproperty
    a_match_a_sets: assert property (p_match_a_sets) else $error("match A flag not set");

    property p_read_clears;
        rd_done && (sel == TSC_SEL_STATUS)
            |=> (evt.flags & $past(reported_q & ~evt.events)) == '0;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

    property p_write_keeps;
        wr_done && (sel == TSC_SEL_STATUS) |=> evt.flags == $past(evt.flags | evt.events);
    endproperty
    a_write_keeps: assert property (p_write_keeps) else $error("status write changed flags");

    property p_masked_sets;
        evt.events[`TSC_BIT_OVF] && !enable_q[`TSC_BIT_OVF]
            |=> evt.flags[`TSC_BIT_OVF] && (irq_out == (|$past(evt.flags & enable_q)));
    endproperty
    a_masked_sets: assert property (p_masked_sets) else $error("masked event handling wrong");

    property p_irq_follows;
        ##1 irq_out == |($past(evt.flags) & $past(enable_q));
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq not matching enabled flags");

    property p_en_ovf_wr;
        wr_done && (sel == TSC_SEL_ENABLE) |=> enable_q[`TSC_BIT_OVF] == $past(pwdata_in[`TSC_BIT_OVF]);
    endproperty
    a_en_ovf_wr: assert property (p_en_ovf_wr) else $error("overflow enable not written");

    property p_en_mb_wr;
        wr_done && (sel == TSC_SEL_ENABLE)
            |=> enable_q[`TSC_BIT_MATCH_B] == $past(pwdata_in[`TSC_BIT_MATCH_B]);
    endproperty
    a_en_mb_wr: assert property (p_en_mb_wr) else $error("match B enable not written");

    property p_en_ma_rd;
        setup && !pwrite_in && (sel == TSC_SEL_ENABLE)
            |=> prdata_out[`TSC_BIT_MATCH_A] == $past(enable_q[`TSC_BIT_MATCH_A]) && pready_out;
    endproperty
    a_en_ma_rd: assert property (p_en_ma_rd) else $error("match A enable readback wrong");

    property p_count_rd;
        setup && !pwrite_in && (sel == TSC_SEL_COUNT)
            |=> prdata_out == `TSC_DATA_W'($past(count_in)) ##1 !pready_out;
    endproperty
    a_count_rd: assert property (p_count_rd) else $error("counter readback wrong");

    property p_cmp_a_wr;
        wr_done && (sel == TSC_SEL_CMP_A) |=> cmp_a_q == $past(pwdata_in[`TSC_CNT_W-1:0]);
    endproperty
    a_cmp_a_wr: assert property (p_cmp_a_wr) else $error("compare A not written");

    property p_cmp_a_upper;
        setup && !pwrite_in && (sel == TSC_SEL_CMP_A) |=> prdata_out[`TSC_DATA_W-1:`TSC_CNT_W] == '0;
    endproperty
    a_cmp_a_upper: assert property (p_cmp_a_upper) else $error("compare A upper bits not zero");

    property p_set_wins;
        rd_done && (sel == TSC_SEL_STATUS) && evt.events[`TSC_BIT_MATCH_A]
            |=> evt.flags[`TSC_BIT_MATCH_A];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost under clearing read");

    property p_ovf_wrap;
        !$past(reset_in) && ($past(count_in) == `TSC_CNT_MAX) && (count_in == '0)
            |-> evt.events[`TSC_BIT_OVF] ##1 evt.flags[`TSC_BIT_OVF];
    endproperty
    a_ovf_wrap: assert property (p_ovf_wrap) else $error("wrap not seen as overflow");

    property p_no_false_ovf;
        evt.events[`TSC_BIT_OVF] |-> $past(count_in) == `TSC_CNT_MAX && count_in == '0;
    endproperty
    a_no_false_ovf: assert property (p_no_false_ovf) else $error("overflow without wrap");

    property p_unmapped_err;
        setup && (sel == TSC_SEL_NONE) |=> pslverr_out && pready_out;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

    property p_ready_after_setup;
        setup |=> pready_out;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");

    property p_ready_one_cycle;
        pready_out |=> !pready_out;
    endproperty
    a_ready_one_cycle: assert property (p_ready_one_cycle) else $error("ready held too long");

    property p_no_stray_ready;
        !setup |=> !pready_out;
    endproperty
    a_no_stray_ready: assert property (p_no_stray_ready) else $error("ready without setup");

    property p_status_rd_data;
        setup && !pwrite_in && (sel == TSC_SEL_STATUS) |=> prdata_out == `TSC_DATA_W'($past(evt.flags));
    endproperty
    a_status_rd_data: assert property (p_status_rd_data) else $error("status readback wrong");

    property p_enable_upper;
        setup && !pwrite_in && (sel == TSC_SEL_ENABLE)
            |=> prdata_out[`TSC_DATA_W-1:`TSC_FLAG_W] == '0;
    endproperty
    a_enable_upper: assert property (p_enable_upper) else $error("enable upper bits not zero");

    property p_masked_quiet;
        enable_q == '0 |=> !irq_out;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("irq with all sources masked");

    property p_flags_hold;
        !(|evt.events) && !(|evt.clear) |=> evt.flags == $past(evt.flags);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flag changed with no event or read");

    property p_match_a_once;
        $past(count_in) == count_in |-> !evt.events[`TSC_BIT_MATCH_A];
    endproperty
    a_match_a_once: assert property (p_match_a_once) else $error("match A refired on held count");

    property p_match_b_entry;
        (count_in == cmp_b_q) && ($past(count_in) != count_in) && !$past(reset_in)
            |-> evt.events[`TSC_BIT_MATCH_B];
    endproperty
    a_match_b_entry: assert property (p_match_b_entry) else $error("match B entry missed");

    c_irq_rise:     cover property ($rose(irq_out));
    c_status_clear: cover property (rd_done && (sel == TSC_SEL_STATUS) && reported_q != '0);
    c_overflow:     cover property (evt.events[`TSC_BIT_OVF]);
    c_back_to_back: cover property (done ##1 setup);

endmodule : tsc_timer_status

// *** timer_status_irq_compare_tb.sv ***
`timescale 1ns/1ns
`include "tsc_cfg.svh"

module timer_status_irq_compare_tb
    import tsc_pkg::*;
;

    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic                    clk_in     = 1'b0;
    logic                    reset_in   = 1'b1;
    logic                    psel_in    = 1'b0;
    logic                    penable_in = 1'b0;
    logic                    pwrite_in  = 1'b0;
    logic [`TSC_ADDR_W-1:0]  paddr_in   = '0;
    tsc_word_t               pwdata_in  = 32'h0000_0000;
    tsc_cnt_t                count_in   = 16'h0000;
    logic                    pready_out;
    tsc_word_t               prdata_out;
    logic                    pslverr_out;
    logic                    irq_out;
    int                      err_total  = 0;
    int                      tests_run  = 0;
    int                      cycles     = 0;

    always #2 clk_in = ~clk_in;

    tsc_timer_status i_tsc_timer_status (
        .clk_in      (clk_in),
        .reset_in    (reset_in),
        .psel_in     (psel_in),
        .penable_in  (penable_in),
        .pwrite_in   (pwrite_in),
        .paddr_in    (paddr_in),
        .pwdata_in   (pwdata_in),
        .pready_out  (pready_out),
        .prdata_out  (prdata_out),
        .pslverr_out (pslverr_out),
        .count_in    (count_in),
        .irq_out     (irq_out)
    );

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input tsc_word_t seen, input tsc_word_t exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Hang guard; the whole sequence needs well under a thousand cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            complete_run();
        end
    end

    // ----------------------------------------
    // APB master
    // ----------------------------------------
    task automatic apb_xfer(input logic wr, input logic [`TSC_ADDR_W-1:0] addr, input tsc_word_t wd,
                            output tsc_word_t rd, output logic er);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= wr;
        paddr_in   <= addr;
        pwdata_in  <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        // Old values are seen here, before this edge's updates land
        rd = prdata_out;
        er = pslverr_out;
        if (n >= 20) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, 32'h0000_0000, 32'h0000_0001);
        end
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb_xfer

    task automatic apb_wr(input logic [`TSC_ADDR_W-1:0] addr, input tsc_word_t wd);
        tsc_word_t rd;
        logic      er;
        apb_xfer(1'b1, addr, wd, rd, er);
    endtask : apb_wr

    task automatic apb_rd(input logic [`TSC_ADDR_W-1:0] addr, input tsc_word_t exp);
        tsc_word_t rd;
        logic      er;
        apb_xfer(1'b0, addr, 32'h0000_0000, rd, er);
        check(rd, exp);
    endtask : apb_rd

    // ----------------------------------------
    // Counter and interrupt helpers
    // ----------------------------------------
    task automatic set_count(input tsc_cnt_t v);
        @(posedge clk_in);
        count_in <= v;
        repeat (2) @(posedge clk_in);
    endtask : set_count

    // Step away first, since a match only fires on entering the value
    task automatic trigger(input int i);
        if (i == 2) begin
            set_count(16'hFFFF);
        end else begin
            set_count(16'h0100);
        end
        set_count(i == 0 ? 16'h0010 : (i == 1 ? 16'h0020 : 16'h0000));
    endtask : trigger

    task automatic chk_irq(input logic exp);
        repeat (3) @(posedge clk_in);
        #1;
        check({31'h0000_0000, irq_out}, {31'h0000_0000, exp});
    endtask : chk_irq

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin : main
        tsc_word_t rd;
        logic      er;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;

        apb_rd(`TSC_OFS_STATUS, 32'h0000_0000);
        apb_rd(`TSC_OFS_ENABLE, 32'h0000_0000);
        apb_rd(`TSC_OFS_COUNT, 32'h0000_0000);
        apb_rd(`TSC_OFS_CMP_A, 32'h0000_0000);
        chk_irq(1'b0);
        $display("test reset values done");

        apb_wr(`TSC_OFS_ENABLE, 32'hFFFF_FFFF);
        apb_rd(`TSC_OFS_ENABLE, 32'h0000_0007);
        apb_wr(`TSC_OFS_ENABLE, 32'h0000_0005);
        apb_rd(`TSC_OFS_ENABLE, 32'h0000_0005);
        apb_wr(`TSC_OFS_ENABLE, 32'h0000_0000);
        apb_wr(`TSC_OFS_CMP_A, 32'hABCD_1234);
        apb_rd(`TSC_OFS_CMP_A, 32'h0000_1234);
        apb_wr(`TSC_OFS_CMP_A, 32'h0000_0010);
        apb_wr(`TSC_OFS_CMP_B, 32'h0000_0020);
        apb_rd(`TSC_OFS_CMP_B, 32'h0000_0020);
        set_count(16'hBEEF);
        apb_rd(`TSC_OFS_COUNT, 32'h0000_BEEF);
        apb_wr(`TSC_OFS_COUNT, 32'h0000_0000);
        apb_rd(`TSC_OFS_COUNT, 32'h0000_BEEF);
        apb_xfer(1'b0, 12'h0FC, 32'h0000_0000, rd, er);
        check(rd, 32'h0000_0000);
        check({31'h0000_0000, er}, 32'h0000_0001);
        $display("test registers done");

        // Flags set with their own source masked; writes must not clear
        for (int i = 0; i < 3; i++) begin
            apb_wr(`TSC_OFS_ENABLE, 32'h0000_0007 & ~(32'h0000_0001 << i));
            trigger(i);
            chk_irq(1'b0);
            apb_wr(`TSC_OFS_STATUS, 32'h0000_0007);
            apb_rd(`TSC_OFS_STATUS, 32'h0000_0001 << i);
            apb_rd(`TSC_OFS_STATUS, 32'h0000_0000);
        end
        // Plain wrap that is not from all ones is no overflow
        set_count(16'h1234);
        set_count(16'h0000);
        apb_rd(`TSC_OFS_STATUS, 32'h0000_0000);
        $display("test masked flags done");

        // Pending flag raises the request once its enable is set
        for (int i = 0; i < 3; i++) begin
            apb_wr(`TSC_OFS_ENABLE, 32'h0000_0000);
            trigger(i);
            chk_irq(1'b0);
            apb_wr(`TSC_OFS_ENABLE, 32'h0000_0001 << i);
            chk_irq(1'b1);
            apb_rd(`TSC_OFS_STATUS, 32'h0000_0001 << i);
            chk_irq(1'b0);
        end
        $display("test interrupt done");

        // Flag A pending; its next event lands on the edge that completes the clearing read
        apb_wr(`TSC_OFS_ENABLE, 32'h0000_0000);
        trigger(0);
        set_count(16'h0100);
        fork
            apb_xfer(1'b0, `TSC_OFS_STATUS, 32'h0000_0000, rd, er);
            begin
                repeat (2) @(posedge clk_in);
                count_in <= 16'h0010;
            end
        join
        check(rd, 32'h0000_0001);
        apb_rd(`TSC_OFS_STATUS, 32'h0000_0001);
        apb_rd(`TSC_OFS_STATUS, 32'h0000_0000);
        $display("test coincident event done");

        complete_run();
    end

endmodule : timer_status_irq_compare_tb
